// ==== hw/search_port_if.sv ====
/*
  Instruction port between host controller and search device.
  Assumes both ends run on the same clock; resolves the shared pins.
*/
`timescale 1ns/100ps

interface search_port_if;
  logic command_valid;
  logic [10:0] cmd;
  logic [71:0] dq_out;
  logic dq_oe_n;
  logic [71:0] dq;
  logic end_of_transfer_out;
  logic end_of_transfer_oe_n;
  logic end_of_transfer;
  logic port_ready;

  // Released bus reads as zero
  assign dq = dq_oe_n ? 72'h0 : dq_out;
  assign end_of_transfer = !end_of_transfer_oe_n && end_of_transfer_out;

  modport host (
    output command_valid, cmd, dq_out, dq_oe_n,
    input dq, end_of_transfer, end_of_transfer_oe_n, port_ready
  );
  modport dev (
    input command_valid, cmd, dq,
    output end_of_transfer_out, end_of_transfer_oe_n, port_ready
  );
endinterface

// ==== hw/search_port_params.svh ====
/*
  Constants of the table-search instruction port: the write opcode, command and
  address field positions, target codes, internal register addresses and
  reset values. Included by the package users; holds definitions only.
*/
`ifndef SEARCH_PORT_PARAMS_SVH
`define SEARCH_PORT_PARAMS_SVH

// ****************************************
// Command bus fields
// ****************************************
`define WR_OPCODE 2'h1
`define CMD_OP_MSB 1
`define CMD_BURST_BIT 2
`define CMD_GMR_LO_MSB 5
`define CMD_GMR_LO_LSB 3
`define CMD_SRAM_MSB 8
`define CMD_SRAM_LSB 6
`define CMD_PARALLEL_BIT 9
`define CMD_GMR_HI_BIT 10

// ****************************************
// Address word fields
// ****************************************
`define DQ_INDIRECT_BIT 29
`define DQ_HIT_MSB 28
`define DQ_HIT_LSB 26
`define DQ_SEL_MSB 25
`define DQ_SEL_LSB 21
`define DQ_TGT_MSB 20
`define DQ_TGT_LSB 19
`define DQ_REG_MSB 6
`define SEL_BROADCAST 5'h1f
`define TGT_DATA 2'h0
`define TGT_MASK 2'h1
`define TGT_SRAM 2'h2
`define TGT_REG 2'h3

// ****************************************
// Internal registers
// ****************************************
`define REG_BURST_SETUP 7'h00
`define REG_GMR_PAGE 3'h1
`define SETUP_ADDR_MSB 15
`define SETUP_LEN_MSB 23
`define SETUP_LEN_LSB 16
`define SETUP_RESET 24'h010000
`define GMR_RESET 72'hff_ffff_ffff_ffff_ffff
`define MASK_ALL 72'hff_ffff_ffff_ffff_ffff

`endif

// ==== hw/search_port_pkg.sv ====
/*
  Types shared by both ends of the table-search write port.
  Assumes the constants header for field widths.
*/
package search_port_pkg;

  typedef enum logic [3:0] {
    dev_idle  = 4'b0001,
    dev_cmd_b = 4'b0010,
    dev_data  = 4'b0100,
    dev_gap   = 4'b1000
  } dev_state_t;

  typedef enum logic [4:0] {
    host_idle  = 5'b00001,
    host_cmd_a = 5'b00010,
    host_cmd_b = 5'b00100,
    host_data  = 5'b01000,
    host_gap   = 5'b10000
  } host_state_t;

  typedef struct packed {
    logic [1:0] target;
    logic [2:0] sram_hi;
    logic [15:0] addr;
    logic [71:0] data;
    logic [71:0] mask;
  } wr_entry_t;

endpackage

// ==== hw/search_table_write_dev.sv ====
/*
  Device end of the write port: decodes write commands, addresses
  arrays, SRAM and internal registers, drives end of transfer and
  hands masked writes to the storage through a two-entry buffer.
  Assumes the host shares clk_sys_i and honours port_ready.
*/
`timescale 1ns/100ps
`include "search_port_params.svh"

// Behaviour
// - Command bit 2 picks single or burst
// - Single write takes exactly three cycles
// - Burst write takes n plus two cycles
// - Host gives valid, opcode, address both phases
// - Host gives mask index in both phases
// - Host gives SRAM upper address bits
// - Bit 9 low for ordinary write
// - Act only on matching or broadcast select
// - Host drives write data after command
// - Fourth cycle idle before next operation
// - Array write touches only mask-enabled bits
// - Host programs burst setup beforehand
// - Burst addresses from incrementing internal register
// - Direct or hit-register indirect addressing
// - Host drives fresh data each burst beat
// - End of transfer high on last beat
// - End of transfer low then released
module search_table_write_dev (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  search_port_if.dev port,
  input wire logic [4:0] device_select_code_i,
  input wire logic [127:0] search_hit_register_i,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [1:0] wr_target_o,
  output logic [2:0] wr_sram_hi_o,
  output logic [15:0] wr_addr_o,
  output logic [71:0] wr_data_o,
  output logic [71:0] wr_mask_o,
  output logic overflow_o
);

  // ****************************************
  // Declarations
  // ****************************************
  search_port_pkg::dev_state_t state;
  search_port_pkg::wr_entry_t slot0;
  search_port_pkg::wr_entry_t slot1;
  search_port_pkg::wr_entry_t push_e;
  logic v0;
  logic v1;
  logic push;
  logic pop;
  logic burst;
  logic selected;
  logic [3:0] gmr_idx;
  logic [2:0] sram_hi;
  logic [1:0] target;
  logic [15:0] addr;
  logic [6:0] reg_addr;
  logic [7:0] left;
  logic [15:0] burst_write_address;
  logic [23:0] burst_write_setup;
  logic [7:0] burst_length_field;
  logic [7:0] first_len;
  logic [71:0] gmr [16];
  logic [15:0] search_hit_register;
  logic [15:0] direct_or_hit;
  logic write_a;
  logic match;
  logic [1:0] tgt_in;
  logic burst_ok;

  // ****************************************
  // Decode
  // ****************************************
  assign write_a = port.command_valid
    && port.cmd[`CMD_OP_MSB:0] == `WR_OPCODE
    && !port.cmd[`CMD_PARALLEL_BIT];

  assign match = port.dq[`DQ_SEL_MSB:`DQ_SEL_LSB] == device_select_code_i
    || port.dq[`DQ_SEL_MSB:`DQ_SEL_LSB] == `SEL_BROADCAST;

  assign tgt_in = port.dq[`DQ_TGT_MSB:`DQ_TGT_LSB];

  // Bursts only reach the two arrays
  assign burst_ok = !burst || tgt_in == `TGT_DATA || tgt_in == `TGT_MASK;

  assign search_hit_register =
    search_hit_register_i[{port.dq[`DQ_HIT_MSB:`DQ_HIT_LSB], 4'h0} +: 16];

  always_comb
  begin
    if (port.dq[`DQ_INDIRECT_BIT])
    begin
      direct_or_hit = {search_hit_register[15:2], search_hit_register[1:0] | port.dq[1:0]};
    end
    else
    begin
      direct_or_hit = port.dq[15:0];
    end
  end

  assign burst_length_field = burst_write_setup[`SETUP_LEN_MSB:`SETUP_LEN_LSB];
  // Zero length would wrap the counter into a 256-beat burst, so it counts as one
  assign first_len = (burst_length_field == 8'h0) ? 8'h1 : burst_length_field;

  // ****************************************
  // Command sequencer
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state <= search_port_pkg::dev_idle;
      burst <= 1'b0;
      selected <= 1'b0;
      gmr_idx <= 4'h0;
      sram_hi <= 3'h0;
      target <= 2'h0;
      addr <= 16'h0;
      reg_addr <= 7'h0;
      left <= 8'h0;
    end
    else if (ce_i)
    begin
      case (state)
        search_port_pkg::dev_idle:
        begin
          if (write_a)
          begin
            state <= search_port_pkg::dev_cmd_b;
            burst <= port.cmd[`CMD_BURST_BIT];
            gmr_idx <= {port.cmd[`CMD_GMR_HI_BIT], port.cmd[`CMD_GMR_LO_MSB:`CMD_GMR_LO_LSB]};
            sram_hi <= port.cmd[`CMD_SRAM_MSB:`CMD_SRAM_LSB];
          end
        end
        search_port_pkg::dev_cmd_b:
        begin
          // A broken second phase drops the command
          if (port.command_valid && !port.cmd[`CMD_PARALLEL_BIT])
          begin
            state <= search_port_pkg::dev_data;
            selected <= match && burst_ok;
            target <= tgt_in;
            addr <= direct_or_hit;
            reg_addr <= port.dq[`DQ_REG_MSB:0];
            left <= burst ? first_len : 8'h1;
          end
          else
          begin
            state <= search_port_pkg::dev_idle;
          end
        end
        search_port_pkg::dev_data:
        begin
          if (left == 8'h1)
          begin
            state <= search_port_pkg::dev_gap;
          end
          left <= left - 8'h1;
        end
        search_port_pkg::dev_gap:
        begin
          state <= search_port_pkg::dev_idle;
        end
        default:
        begin
          state <= search_port_pkg::dev_idle;
        end
      endcase
    end
  end

  // ****************************************
  // End of transfer pin
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      port.end_of_transfer_out <= 1'b0;
      port.end_of_transfer_oe_n <= 1'b1;
    end
    else if (ce_i)
    begin
      if (state == search_port_pkg::dev_cmd_b && port.command_valid
          && burst && match && burst_ok && first_len == 8'h1)
      begin
        port.end_of_transfer_oe_n <= 1'b0;
        port.end_of_transfer_out <= 1'b1;
      end
      else if (state == search_port_pkg::dev_data && burst && selected)
      begin
        port.end_of_transfer_oe_n <= 1'b0;
        port.end_of_transfer_out <= (left == 8'h2);
      end
      else
      begin
        port.end_of_transfer_oe_n <= 1'b1;
        port.end_of_transfer_out <= 1'b0;
      end
    end
  end

  // ****************************************
  // Internal registers
  // ****************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      burst_write_setup <= `SETUP_RESET;
      burst_write_address <= 16'h0;
      for (int i = 0; i < 16; i++)
      begin
        gmr[i] <= `GMR_RESET;
      end
    end
    else if (ce_i)
    begin
      if (state == search_port_pkg::dev_cmd_b && burst)
      begin
        burst_write_address <= burst_write_setup[`SETUP_ADDR_MSB:0];
      end
      else if (state == search_port_pkg::dev_data && selected && burst)
      begin
        burst_write_address <= burst_write_address + 16'h1;
      end
      if (state == search_port_pkg::dev_data && selected && target == `TGT_REG)
      begin
        if (reg_addr == `REG_BURST_SETUP)
        begin
          burst_write_setup <= port.dq[`SETUP_LEN_MSB:0];
        end
        else if (reg_addr[6:4] == `REG_GMR_PAGE)
        begin
          gmr[reg_addr[3:0]] <= port.dq;
        end
      end
    end
  end

  // ****************************************
  // Outgoing two-entry buffer
  // ****************************************
  assign push = state == search_port_pkg::dev_data && selected && target != `TGT_REG;
  assign pop = v0 && wr_ready_i;

  always_comb
  begin
    push_e.target = target;
    push_e.sram_hi = sram_hi;
    push_e.addr = burst ? burst_write_address : addr;
    push_e.data = port.dq;
    // Storage merges data under this mask, leaving other bits alone
    push_e.mask = (target == `TGT_SRAM) ? `MASK_ALL : gmr[gmr_idx];
  end

  // A stalled sink over a long burst can still overrun two entries;
  // the host waits on port_ready, and overflow_o records any loss.
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      v0 <= 1'b0;
      v1 <= 1'b0;
      slot0 <= '0;
      slot1 <= '0;
      overflow_o <= 1'b0;
      port.port_ready <= 1'b0;
    end
    else if (ce_i)
    begin
      if (pop)
      begin
        if (v1)
        begin
          slot0 <= slot1;
          slot1 <= push_e;
          v1 <= push;
        end
        else
        begin
          slot0 <= push_e;
          v0 <= push;
        end
      end
      else if (push)
      begin
        if (!v0)
        begin
          slot0 <= push_e;
          v0 <= 1'b1;
        end
        else if (!v1)
        begin
          slot1 <= push_e;
          v1 <= 1'b1;
        end
        else
        begin
          overflow_o <= 1'b1;
        end
      end
      port.port_ready <= !v0 && !v1 && !push;
    end
  end

  assign wr_valid_o = v0;
  assign wr_target_o = slot0.target;
  assign wr_sram_hi_o = slot0.sram_hi;
  assign wr_addr_o = slot0.addr;
  assign wr_data_o = slot0.data;
  assign wr_mask_o = slot0.mask;

endmodule

// ==== hw/search_table_write_host.sv ====
/*
  Host end of the write port: turns one request into the two command
  phases, the data cycles and the closing idle cycle.
  Assumes the user supplies data_i in every cycle that data_req_o is high.
*/
`timescale 1ns/100ps
`include "search_port_params.svh"

module search_table_write_host (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ce_i,
  search_port_if.host port,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_burst_i,
  input wire logic [1:0] req_target_i,
  input wire logic req_indirect_i,
  input wire logic [2:0] req_hit_index_i,
  input wire logic [4:0] req_select_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [3:0] req_gmr_index_i,
  input wire logic [2:0] req_sram_hi_i,
  input wire logic [7:0] req_length_i,
  output logic data_req_o,
  input wire logic [71:0] data_i,
  output logic done_o
);

  // ****************************************
  // Sequencer
  // ****************************************
  search_port_pkg::host_state_t state;
  logic [7:0] left;
  logic take;

  assign take = state == search_port_pkg::host_idle && req_valid_i && req_ready_o;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state <= search_port_pkg::host_idle;
      left <= 8'h0;
      req_ready_o <= 1'b0;
      data_req_o <= 1'b0;
      done_o <= 1'b0;
      port.command_valid <= 1'b0;
      port.cmd <= 11'h0;
      port.dq_out <= 72'h0;
      port.dq_oe_n <= 1'b1;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      case (state)
        search_port_pkg::host_idle:
        begin
          req_ready_o <= port.port_ready && !take;
          if (take)
          begin
            state <= search_port_pkg::host_cmd_a;
            left <= (req_burst_i && req_length_i != 8'h0) ? req_length_i : 8'h1;
            port.command_valid <= 1'b1;
            port.cmd <= {req_gmr_index_i[3], 1'b0, req_sram_hi_i, req_gmr_index_i[2:0],
              req_burst_i, `WR_OPCODE};
            port.dq_out <= {42'h0, req_indirect_i, req_hit_index_i, req_select_i,
              req_target_i, 3'h0, req_addr_i};
            port.dq_oe_n <= 1'b0;
          end
        end
        search_port_pkg::host_cmd_a:
        begin
          state <= search_port_pkg::host_cmd_b;
          data_req_o <= 1'b1;
        end
        search_port_pkg::host_cmd_b:
        begin
          state <= search_port_pkg::host_data;
          port.command_valid <= 1'b0;
          port.dq_out <= data_i;
          data_req_o <= left != 8'h1;
        end
        search_port_pkg::host_data:
        begin
          left <= left - 8'h1;
          if (left == 8'h1)
          begin
            state <= search_port_pkg::host_gap;
            port.dq_oe_n <= 1'b1;
          end
          else
          begin
            port.dq_out <= data_i;
            data_req_o <= left != 8'h2;
          end
        end
        search_port_pkg::host_gap:
        begin
          state <= search_port_pkg::host_idle;
          done_o <= 1'b1;
        end
        default:
        begin
          state <= search_port_pkg::host_idle;
        end
      endcase
    end
  end

endmodule

// ==== verification/search_table_write_checker.sv ====
/*
  Checker of the wires between the host and device ends of the write port.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`include "search_port_params.svh"

module search_table_write_checker (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic command_valid,
  input wire logic [10:0] cmd,
  input wire logic dq_oe_n,
  input wire logic end_of_transfer_out,
  input wire logic end_of_transfer_oe_n,
  input wire logic end_of_transfer
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************
  // Command phases
  // ****************************************
  cmd_pair_a:
  assert property ($rose(command_valid) |=> command_valid ##1 !command_valid)
    else $error("command phases not exactly two cycles");
  write_opcode_a:
  assert property (command_valid |-> cmd[1:0] == `WR_OPCODE && !cmd[`CMD_PARALLEL_BIT])
    else $error("bad opcode or parallel bit in command phase");
  cmd_drive_a:
  assert property (command_valid |-> !dq_oe_n)
    else $error("address not driven in command phase");
  data_drive_a:
  assert property ($fell(command_valid) |-> !dq_oe_n)
    else $error("data not driven after command phases");
  // Burst bit is read from phase 1A, two samples back
  single_idle_a:
  assert property (($fell(command_valid) && !$past(cmd[2], 2))
    |=> dq_oe_n && !command_valid && end_of_transfer_oe_n)
    else $error("single write not closed by an idle cycle");

  // ****************************************
  // End of transfer
  // ****************************************
  eot_close_a:
  assert property ($rose(end_of_transfer)
    |=> (!end_of_transfer_oe_n && !end_of_transfer_out) ##1 end_of_transfer_oe_n)
    else $error("end of transfer not driven low then released");
  eot_in_data_a:
  assert property (end_of_transfer |-> !command_valid && !dq_oe_n)
    else $error("end of transfer high outside a data beat");
  eot_quiet_a:
  assert property (command_valid |-> end_of_transfer_oe_n)
    else $error("end of transfer driven during a command phase");
endmodule

// ==== verification/search_table_write_port_test.sv ====
/*
  Testbench joining host and device ends of the write port.
  Assumes the user side drives requests and pops the device buffer.
*/
`timescale 1ns/100ps
`include "search_port_params.svh"

module search_table_write_port_test;
  localparam logic [4:0] SEL = 5'h0a;
  localparam logic [15:0] HIT2 = 16'h1234;
  localparam logic [71:0] M5 = 72'h0f_0000_0000_0000_00ff;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0, req_burst_i = 1'b0, req_indirect_i = 1'b0;
  logic [1:0] req_target_i = 2'h0;
  logic [2:0] req_hit_index_i = 3'h2, req_sram_hi_i = 3'h0;
  logic [4:0] req_select_i = 5'h00;
  logic [15:0] req_addr_i = 16'h0000;
  logic [3:0] req_gmr_index_i = 4'h0;
  logic [7:0] req_length_i = 8'h01;
  logic wr_ready_i = 1'b0;
  logic [127:0] hit_regs = {80'h0, HIT2, 32'h0};
  logic [71:0] dbuf [0:3];
  int beat = 0;
  int fail_count = 0;
  int n_tests = 0;
  logic req_ready_o, data_req_o, done_o, wr_valid_o, overflow_o;
  logic [1:0] wr_target_o;
  logic [2:0] wr_sram_hi_o;
  logic [15:0] wr_addr_o;
  logic [71:0] wr_data_o, wr_mask_o, data_i;

  search_port_if search_port_if_inst ();
  search_table_write_host search_table_write_host_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ce_i(1'b1), .port(search_port_if_inst), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_burst_i(req_burst_i), .req_target_i(req_target_i),
    .req_indirect_i(req_indirect_i), .req_hit_index_i(req_hit_index_i),
    .req_select_i(req_select_i), .req_addr_i(req_addr_i), .req_gmr_index_i(req_gmr_index_i),
    .req_sram_hi_i(req_sram_hi_i), .req_length_i(req_length_i), .data_req_o(data_req_o),
    .data_i(data_i), .done_o(done_o));
  search_table_write_dev search_table_write_dev_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ce_i(1'b1), .port(search_port_if_inst), .device_select_code_i(SEL),
    .search_hit_register_i(hit_regs), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
    .wr_target_o(wr_target_o), .wr_sram_hi_o(wr_sram_hi_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .wr_mask_o(wr_mask_o), .overflow_o(overflow_o));
  search_table_write_checker search_table_write_checker_inst (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .command_valid(search_port_if_inst.command_valid),
    .cmd(search_port_if_inst.cmd), .dq_oe_n(search_port_if_inst.dq_oe_n),
    .end_of_transfer_out(search_port_if_inst.end_of_transfer_out),
    .end_of_transfer_oe_n(search_port_if_inst.end_of_transfer_oe_n),
    .end_of_transfer(search_port_if_inst.end_of_transfer));

  // ****************************************
  // Clock, data feed and tasks
  // ****************************************
  always #12.5 clk_sys_i = ~clk_sys_i;

  // Data must stand in the cycle the host asks for it, so it is combinational
  assign data_i = dbuf[beat];
  always @(posedge clk_sys_i)
    if (data_req_o === 1'b1)
      beat <= beat + 1;

  task automatic cmp(input string what, input logic [71:0] exp, input logic [71:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One request; checks the cycles from take to done
  task automatic req(input logic b, input logic [1:0] t, input logic ind, input logic [4:0] sel,
      input logic [15:0] a, input logic [3:0] g, input logic [2:0] s, input int cyc);
    int k;
    k = 0;
    do
    begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end while (req_ready_o !== 1'b1 && k < 200);
    cmp("req_ready_o before request", 72'h1, 72'(req_ready_o));
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_burst_i <= b;
    req_target_i <= t;
    req_indirect_i <= ind;
    req_select_i <= sel;
    req_addr_i <= a;
    req_gmr_index_i <= g;
    req_sram_hi_i <= s;
    beat <= 0;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end while (done_o !== 1'b1 && k < 300);
    cmp("cycles to done", 72'(cyc), 72'(k));
  endtask

  // Checks the buffer head, then pops it with a one-cycle ready
  task automatic pop(input logic [1:0] t, input logic [2:0] s, input logic [15:0] a,
      input logic [71:0] d, input logic [71:0] m);
    cmp("wr_valid_o", 72'h1, 72'(wr_valid_o));
    cmp("wr_target_o", 72'(t), 72'(wr_target_o));
    cmp("wr_sram_hi_o", 72'(s), 72'(wr_sram_hi_o));
    cmp("wr_addr_o", 72'(a), 72'(wr_addr_o));
    cmp("wr_data_o", d, wr_data_o);
    cmp("wr_mask_o", m, wr_mask_o);
    @(posedge clk_sys_i);
    wr_ready_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_ready_i <= 1'b0;
    #1;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    #(25ns * 4000);
    fail_count++;
    test_done;
  end

  initial
  begin
    dbuf = '{72'h0, 72'h0, 72'h0, 72'h0};
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    dbuf[0] = M5;
    // Edges from take to done: two command phases, data beats, idle, then done
    req(0, `TGT_REG, 0, SEL, 16'h0015, 4'h0, 3'h0, 4);
    cmp("register write stays inside", 72'h0, 72'(wr_valid_o));
    dbuf[0] = 72'hab_cdef_0123_4567_89ab;
    req(0, `TGT_DATA, 0, SEL, 16'h0123, 4'h5, 3'h0, 4);
    pop(`TGT_DATA, 3'h0, 16'h0123, dbuf[0], M5);
    dbuf[0] = 72'h12_3456_789a_bcde_f012;
    req(0, `TGT_MASK, 1, SEL, 16'h0003, 4'h0, 3'h0, 4);
    pop(`TGT_MASK, 3'h0, HIT2 | 16'h0003, dbuf[0], `MASK_ALL);
    dbuf[0] = 72'h5a_5a5a_5a5a_5a5a_5a5a;
    req(0, `TGT_SRAM, 0, `SEL_BROADCAST, 16'h0042, 4'h0, 3'h5, 4);
    pop(`TGT_SRAM, 3'h5, 16'h0042, dbuf[0], `MASK_ALL);
    req(0, `TGT_DATA, 0, 5'h03, 16'h0007, 4'h5, 3'h0, 4);
    cmp("unselected write dropped", 72'h0, 72'(wr_valid_o));
    // Burst setup: length 2 from address 0x0100
    dbuf[0] = 72'h02_0100;
    req(0, `TGT_REG, 0, SEL, 16'h0000, 4'h0, 3'h0, 4);
    dbuf[0] = 72'h11_1111_1111_1111_1111;
    dbuf[1] = 72'h22_2222_2222_2222_2222;
    req_length_i <= 8'h02;
    req(1, `TGT_DATA, 0, SEL, 16'hbeef, 4'h5, 3'h0, 5);
    // Host looks at port_ready only once back in idle, so wait one edge
    @(posedge clk_sys_i);
    #1;
    cmp("req_ready_o full buffer", 72'h0, 72'(req_ready_o));
    pop(`TGT_DATA, 3'h0, 16'h0100, dbuf[0], M5);
    pop(`TGT_DATA, 3'h0, 16'h0101, dbuf[1], M5);
    cmp("overflow_o", 72'h0, 72'(overflow_o));
    cmp("wr_valid_o drained", 72'h0, 72'(wr_valid_o));
    test_done;
  end
endmodule
